/* hw/pwr_consts.svh */
// Constants for the power-mode controller: offsets, fields, resets, timing.
// Assumes a 40 MHz system clock and an 8-bit register port.
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// ==========================================================
// Timing
`define CLK_HZ 40000000
`define US_CYCLES(us) ((us) * (`CLK_HZ / 1000000))
`define DBNC_SHORT_US 31250
`define DBNC_MID_US 125000
`define DBNC_LONG_US 750000
`define LONG_PRESS_US 4000000
`define CNT_W 28

// ==========================================================
// Register offsets
`define REG_CTRL 8'h00
`define REG_KEEPON 8'h01
`define REG_SP_BUCK1 8'h02
`define REG_SP_BUCK2 8'h03
`define REG_SP_BUCK3 8'h04
`define REG_IRQ_MASK 8'h05
`define REG_STATUS 8'h06

// ==========================================================
// Fields
`define CTRL_MODE 0
`define CTRL_LPOFF 1
`define CTRL_RESTART 2
`define CTRL_DBNC 3
`define CTRL_STBYINV 5
`define STAT_FLAG 0
`define STAT_SENSE 1
`define STAT_STATE 2

// ==========================================================
// Reset values
`define CTRL_RST 6'h00
`define KEEPON_RST 3'h0
`define SP1_RST 6'h00
`define SP_RST 7'h00
`define MASK_RST 5'h00

// ==========================================================
// State codes seen in status
`define SC_COIN 3'h0
`define SC_OFF 3'h1
`define SC_SLEEP 3'h2
`define SC_STBY 3'h3
`define SC_ON 3'h4

`endif

/* hw/pwr_pkg.sv */
// Types for the power-mode controller.
// Assumes pwr_consts.svh is on the include path.
`include "pwr_consts.svh"

package pwr_pkg;
	typedef enum logic [2:0] {ST_COIN, ST_OFF, ST_SLEEP, ST_STBY, ST_ON}
		pwr_state_t;
	typedef logic [`CNT_W-1:0] dcount_t;
endpackage

/* hw/btn_if.sv */
// Link between the state controller and the button timer.
// Assumes both ends run on clk_sys.
interface btn_if;
	import pwr_pkg::*;
	logic btn;
	dcount_t on_lim;
	dcount_t fall_lim;
	dcount_t rise_lim;
	dcount_t long_lim;
	logic press_evt;
	logic fall_evt;
	logic rise_evt;
	logic long_evt;
	modport timer (input btn, on_lim, fall_lim, rise_lim, long_lim,
		output press_evt, fall_evt, rise_evt, long_evt);
	modport ctrl (output btn, on_lim, fall_lim, rise_lim, long_lim,
		input press_evt, fall_evt, rise_evt, long_evt);
endinterface

/* hw/btn_timer.sv */
// Button stability timer: counts cycles at the current level, pulses events.
// Assumes the button level arrives already synchronised.
module btn_timer
	import pwr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	btn_if.timer bt
);
	dcount_t cnt_q;
	dcount_t cnt_d;
	logic lvl_q;
	wire changed = bt.btn != lvl_q;
	wire at_max = &cnt_q;
	wire low_now = !bt.btn;

	// ==========================================================
	// Counter
	assign cnt_d = changed ? '0 : (at_max ? cnt_q : cnt_q + 1'b1);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lvl_q <= 1'b1;
			cnt_q <= '0;
		end else begin
			lvl_q <= bt.btn;
			cnt_q <= cnt_d;
		end
	end

	// ==========================================================
	// Events
	assign bt.press_evt = low_now && cnt_d == bt.on_lim;
	assign bt.fall_evt = low_now && cnt_d == bt.fall_lim;
	assign bt.rise_evt = !low_now && cnt_d == bt.rise_lim;
	assign bt.long_evt = low_now && cnt_d == bt.long_lim;
endmodule

/* hw/pwr_mode_ctrl.sv */
// Power-mode state controller with register port and button timing.
// Assumes srst is the backup-rail power-on reset and inputs are async pins.
//
// How it works
// - ON or Standby goes to Sleep on button release with a keep-on bit set
// - Sleep returns to ON on button assertion with input voltage valid
// - Sleep uses latched 6-bit and 7-bit sleep set points until turn-on
// - Interrupt output stays live in Sleep for unmasked faults
// - Keep-on bit 0 turns a buck off in Sleep, 1 keeps it in PFM
// - Coin-Cell ignores every turn-on event
// - Coin-Cell goes to OFF only when input voltage is valid
// - Host reset is held low throughout Coin-Cell
// - Backup power loss resets everything, all control bits to defaults
// - OFF or Sleep turn on by level high or debounced press under 4 s
// - Release or long press with any keep-on bit goes to Sleep
// - Release or long press with no keep-on bit goes to OFF
// - Mode bit 0 is level active-high, 1 is mechanical switch
// - Level mode turn-on sets the button event flag
// - Switch mode falling-edge turn-on sets the button event flag
// - Level high before voltage is valid turns on once voltage rises
// - Bucks kept on in Sleep stay on into ON without restart
// - Sense bit is the live undebounced button level
// - Switch mode raises event flag on debounced falling and rising edges
// - Debounce select sets turn-on and falling debounce, rising fixed
// - Event flag holds until software clears it or state is OFF
// - Auto restart turns a long-press power-off into a restart
// - Thermal shutdown forces OFF and blocks turn-on while hot
// - ON enters Standby on corrected standby input, returns on release
// - Input voltage below threshold sends any powered state to Coin-Cell
// - Host reset high in ON, low in OFF
`include "pwr_consts.svh"

module pwr_mode_ctrl
	import pwr_pkg::*;
#(
	parameter int DBNC_SHORT_CYC = `US_CYCLES(`DBNC_SHORT_US),
	parameter int DBNC_MID_CYC = `US_CYCLES(`DBNC_MID_US),
	parameter int DBNC_LONG_CYC = `US_CYCLES(`DBNC_LONG_US),
	parameter int LONG_PRESS_CYC = `US_CYCLES(`LONG_PRESS_US)
)
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic power_button_input,
	input wire logic standby_in,
	input wire logic vin_above_uv,
	input wire logic thermal_shutdown,
	input wire logic [3:0] fault_in,
	output logic irq_out_n,
	output logic host_reset_out_n,
	output logic [2:0] buck_enable,
	output logic [2:0] buck_pfm,
	output logic buck_sleep_sel,
	output logic [2:0] buck_startup_req,
	output logic [5:0] buck1_sleep_setpoint,
	output logic [6:0] buck2_sleep_setpoint,
	output logic [6:0] buck3_sleep_setpoint,
	output logic [2:0] power_state
);
	localparam int SYNC_W = 8;

	btn_if bt ();

	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic [5:0] ctrl_q;
	logic [2:0] sleep_keep_on_select;
	logic [5:0] sp1_q;
	logic [6:0] sp2_q;
	logic [6:0] sp3_q;
	logic [4:0] mask_q;
	logic button_event_flag;
	logic flag_d;
	logic restart_q;
	logic restart_d;
	pwr_state_t state_q;
	pwr_state_t state_d;
	logic [2:0] state_code;
	logic [2:0] next_code;
	logic [7:0] rd_mux;

	// ==========================================================
	// Input synchronisers
	wire [SYNC_W-1:0] raw_in = {fault_in, thermal_shutdown, vin_above_uv,
		standby_in, power_button_input};

	generate
		for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= raw_in[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	wire btn_s = sync_q[0];
	wire vin_s = sync_q[2];
	wire tsd_s = sync_q[3];
	wire [3:0] fault_s = sync_q[7:4];
	wire stby_ctl = sync_q[1] ^ ctrl_q[`CTRL_STBYINV];

	// ==========================================================
	// Control decode
	wire button_mode_select = ctrl_q[`CTRL_MODE];
	wire long_press_off_enable = ctrl_q[`CTRL_LPOFF];
	wire auto_restart_enable = ctrl_q[`CTRL_RESTART];
	wire [1:0] button_debounce_select = ctrl_q[`CTRL_DBNC+1:`CTRL_DBNC];
	wire any_keep = |sleep_keep_on_select;
	wire powered = state_q == ST_SLEEP || state_q == ST_STBY
		|| state_q == ST_ON;
	wire can_wake = state_q == ST_OFF || state_q == ST_SLEEP;

	// ==========================================================
	// Button timer
	wire dcount_t lim_short = dcount_t'(DBNC_SHORT_CYC);
	wire dcount_t lim_mid = dcount_t'(DBNC_MID_CYC);
	wire dcount_t lim_long = dcount_t'(DBNC_LONG_CYC);

	assign bt.btn = btn_s;
	assign bt.on_lim = button_debounce_select == 2'h0 ? '0 :
		button_debounce_select == 2'h1 ? lim_short :
		button_debounce_select == 2'h2 ? lim_mid : lim_long;
	assign bt.fall_lim = button_debounce_select == 2'h2 ? lim_mid :
		button_debounce_select == 2'h3 ? lim_long : lim_short;
	assign bt.rise_lim = lim_short;
	assign bt.long_lim = dcount_t'(LONG_PRESS_CYC);

	btn_timer u_btn_timer (
		.clk_sys(clk_sys),
		.srst(srst),
		.bt(bt)
	);

	// ==========================================================
	// Turn-on and turn-off qualification
	wire level_on = !button_mode_select && btn_s;
	wire switch_on = button_mode_select && bt.press_evt;
	wire on_req = vin_s && !tsd_s
		&& (level_on || switch_on);
	wire long_off = button_mode_select && long_press_off_enable
		&& bt.long_evt;
	wire off_req = button_mode_select ? long_off : !btn_s;
	wire restart_go = long_off && auto_restart_enable;

	// ==========================================================
	// State machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_COIN: begin
				// Turn-on requests are never decoded here
				if (vin_s) begin
					state_d = ST_OFF;
				end
			end
			ST_OFF: begin
				if (!vin_s) begin
					state_d = ST_COIN;
				end else if (restart_q && !tsd_s) begin
					state_d = ST_ON;
				end else if (on_req) begin
					state_d = ST_ON;
				end
			end
			ST_SLEEP: begin
				if (!vin_s) begin
					state_d = ST_COIN;
				end else if (tsd_s) begin
					state_d = ST_OFF;
				end else if (on_req) begin
					state_d = ST_ON;
				end else if (long_off) begin
					state_d = ST_OFF;
				end
			end
			ST_STBY, ST_ON: begin
				if (!vin_s) begin
					state_d = ST_COIN;
				end else if (tsd_s) begin
					state_d = ST_OFF;
				end else if (off_req && any_keep) begin
					state_d = ST_SLEEP;
				end else if (off_req) begin
					state_d = ST_OFF;
				end else if (state_q == ST_ON && stby_ctl) begin
					state_d = ST_STBY;
				end else if (state_q == ST_STBY && !stby_ctl) begin
					state_d = ST_ON;
				end
			end
			default: begin
				state_d = ST_COIN;
			end
		endcase
	end

	// Restart request survives one pass through OFF
	assign restart_d = state_q == ST_COIN ? 1'b0 :
		(powered && state_d == ST_OFF && restart_go) ? 1'b1 :
		(state_q == ST_OFF && state_d == ST_ON) ? 1'b0 : restart_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= ST_COIN;
			restart_q <= 1'b0;
		end else begin
			state_q <= state_d;
			restart_q <= restart_d;
		end
	end

	// ==========================================================
	// Button event flag
	wire wr_status = reg_wr && reg_addr == `REG_STATUS;
	wire flag_clr = (wr_status && reg_wdata[`STAT_FLAG])
		|| state_q == ST_OFF;
	wire edge_set = button_mode_select && (bt.fall_evt || bt.rise_evt);
	wire wake_set = can_wake && on_req;
	wire flag_set = state_q != ST_COIN && (edge_set || wake_set);
	assign flag_d = flag_set || (button_event_flag && !flag_clr);

	// ==========================================================
	// Registers
	wire wr_ctrl = reg_wr && reg_addr == `REG_CTRL;
	wire wr_keep = reg_wr && reg_addr == `REG_KEEPON;
	wire wr_sp1 = reg_wr && reg_addr == `REG_SP_BUCK1;
	wire wr_sp2 = reg_wr && reg_addr == `REG_SP_BUCK2;
	wire wr_sp3 = reg_wr && reg_addr == `REG_SP_BUCK3;
	wire wr_mask = reg_wr && reg_addr == `REG_IRQ_MASK;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_q <= `CTRL_RST;
			sleep_keep_on_select <= `KEEPON_RST;
			sp1_q <= `SP1_RST;
			sp2_q <= `SP_RST;
			sp3_q <= `SP_RST;
			mask_q <= `MASK_RST;
			button_event_flag <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl_q <= reg_wdata[5:0];
			if (wr_keep) sleep_keep_on_select <= reg_wdata[2:0];
			if (wr_sp1) sp1_q <= reg_wdata[5:0];
			if (wr_sp2) sp2_q <= reg_wdata[6:0];
			if (wr_sp3) sp3_q <= reg_wdata[6:0];
			if (wr_mask) mask_q <= reg_wdata[4:0];
			button_event_flag <= flag_d;
		end
	end

	always_comb begin
		case (state_q)
			ST_COIN: state_code = `SC_COIN;
			ST_OFF: state_code = `SC_OFF;
			ST_SLEEP: state_code = `SC_SLEEP;
			ST_STBY: state_code = `SC_STBY;
			ST_ON: state_code = `SC_ON;
			default: state_code = `SC_COIN;
		endcase
	end

	always_comb begin
		case (state_d)
			ST_COIN: next_code = `SC_COIN;
			ST_OFF: next_code = `SC_OFF;
			ST_SLEEP: next_code = `SC_SLEEP;
			ST_STBY: next_code = `SC_STBY;
			ST_ON: next_code = `SC_ON;
			default: next_code = `SC_COIN;
		endcase
	end

	wire [7:0] status_word = {3'h0, state_code, btn_s,
		button_event_flag};
	assign rd_mux =
		reg_addr == `REG_CTRL ? {2'h0, ctrl_q} :
		reg_addr == `REG_KEEPON ? {5'h00, sleep_keep_on_select} :
		reg_addr == `REG_SP_BUCK1 ? {2'h0, sp1_q} :
		reg_addr == `REG_SP_BUCK2 ? {1'b0, sp2_q} :
		reg_addr == `REG_SP_BUCK3 ? {1'b0, sp3_q} :
		reg_addr == `REG_IRQ_MASK ? {3'h0, mask_q} :
		reg_addr == `REG_STATUS ? status_word : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ==========================================================
	// Outputs
	wire irq_live = (button_event_flag && !mask_q[0])
		|| |(fault_s & ~mask_q[4:1]);
	wire host_up = state_d == ST_ON || state_d == ST_STBY;
	wire powered_next = state_d == ST_SLEEP || state_d == ST_STBY
		|| state_d == ST_ON;
	wire to_sleep = state_d == ST_SLEEP && state_q != ST_SLEEP;
	wire run_next = state_d == ST_ON || state_d == ST_STBY;
	wire [2:0] en_next = run_next ? 3'h7 :
		state_d == ST_SLEEP ? sleep_keep_on_select : 3'h0;
	wire wake_edge = can_wake && state_d == ST_ON;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_out_n <= 1'b1;
			host_reset_out_n <= 1'b0;
			buck_enable <= 3'h0;
			buck_pfm <= 3'h0;
			buck_sleep_sel <= 1'b0;
			buck_startup_req <= 3'h0;
			buck1_sleep_setpoint <= `SP1_RST;
			buck2_sleep_setpoint <= `SP_RST;
			buck3_sleep_setpoint <= `SP_RST;
			power_state <= `SC_COIN;
		end else begin
			irq_out_n <= !(powered_next && irq_live);
			host_reset_out_n <= host_up;
			buck_enable <= en_next;
			buck_pfm <= state_d == ST_SLEEP ? sleep_keep_on_select
				: 3'h0;
			buck_sleep_sel <= state_d == ST_SLEEP;
			buck_startup_req <= wake_edge ? ~buck_enable : 3'h0;
			if (to_sleep) begin
				buck1_sleep_setpoint <= sp1_q;
				buck2_sleep_setpoint <= sp2_q;
				buck3_sleep_setpoint <= sp3_q;
			end
			power_state <= next_code;
		end
	end
endmodule

/* dv/board_model.sv */
// Board model: power button, standby pin, input supply, die temperature.
// Assumes the bench sets wanted levels just after a rising clk_sys edge.
module board_model (
	input wire logic clk_sys,
	input wire logic [3:0] want,
	output logic power_button_input,
	output logic standby_in,
	output logic vin_above_uv,
	output logic thermal_shutdown
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Pins settle one edge after each request
	logic [3:0] pins_q = 4'h0;
	always @(posedge clk_sys) pins_q <= want;
	assign {thermal_shutdown, vin_above_uv, standby_in,
		power_button_input} = pins_q;
endmodule

/* dv/pwr_mode_asserts.sv */
// Concurrent checks on the power-mode controller ports.
// Assumes binding into pwr_mode_ctrl with clk_sys at 40 MHz.
module pwr_mode_asserts (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic vin_above_uv,
	input wire logic thermal_shutdown,
	input wire logic host_reset_out_n,
	input wire logic [2:0] buck_enable,
	input wire logic [2:0] buck_pfm,
	input wire logic [2:0] buck_startup_req,
	input wire logic [5:0] buck1_sleep_setpoint,
	input wire logic [2:0] power_state
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// State and output relations
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	coin_exit_a: assert property (
		power_state == 3'h0 |=> power_state inside {3'h0, 3'h1})
		else $error("coin-cell left to a powered state");
	coin_rst_a: assert property (
		power_state == 3'h0 |-> !host_reset_out_n) else $error("reset high");
	host_rst_a: assert property (
		power_state inside {3'h1, 3'h4} |->
		host_reset_out_n == (power_state == 3'h4)) else $error("reset wrong");
	uv_coin_a: assert property (
		!vin_above_uv [*5] |=> power_state == 3'h0) else $error("not coin");
	hot_off_a: assert property (
		thermal_shutdown [*5] |=> power_state inside {3'h0, 3'h1})
		else $error("powered while hot");
	sleep_mode_a: assert property (
		power_state == 3'h2 |-> buck_pfm == buck_enable)
		else $error("sleep buck mode wrong");
	sleep_hold_a: assert property (
		power_state == 3'h2 ##1 power_state == 3'h2 |->
		$stable(buck1_sleep_setpoint)) else $error("sleep set point moved");
	sleep_from_a: assert property (
		power_state == 3'h2 |-> $past(power_state) inside {3'h2, 3'h3, 3'h4})
		else $error("sleep from wrong state");
	stby_from_a: assert property (
		power_state == 3'h3 |-> $past(power_state) inside {3'h3, 3'h4})
		else $error("standby from wrong state");
	start_req_a: assert property (
		buck_startup_req != 3'h0 |->
		power_state == 3'h4 && buck_startup_req == ~$past(buck_enable))
		else $error("start-up request wrong");
endmodule

bind pwr_mode_ctrl pwr_mode_asserts chk_i (
	.clk_sys(clk_sys), .srst(srst), .vin_above_uv(vin_above_uv),
	.thermal_shutdown(thermal_shutdown),
	.host_reset_out_n(host_reset_out_n), .buck_enable(buck_enable),
	.buck_pfm(buck_pfm), .buck_startup_req(buck_startup_req),
	.buck1_sleep_setpoint(buck1_sleep_setpoint), .power_state(power_state)
);

/* dv/tb.sv */
// Bench for the power-mode controller: register tasks and mode scenarios.
// Assumes the design, board model and checker are compiled before it.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, srst, reg_wr, reg_rd, btn, stby, vin, hot;
	logic power_button_input, standby_in, vin_above_uv, thermal_shutdown;
	logic irq_out_n, host_reset_out_n, sel;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [3:0] fault_in;
	logic [2:0] buck_enable, buck_pfm, buck_startup_req, power_state, su;
	logic [5:0] sp1;
	logic [6:0] sp2, sp3;
	int fail_count, n_tests;

	// ==========================================================
	// Board model and design
	board_model brd (.clk_sys(clk_sys), .want({hot, vin, stby, btn}),
		.power_button_input(power_button_input), .standby_in(standby_in),
		.vin_above_uv(vin_above_uv), .thermal_shutdown(thermal_shutdown));
	pwr_mode_ctrl #(.DBNC_SHORT_CYC(8), .DBNC_MID_CYC(16),
		.DBNC_LONG_CYC(24), .LONG_PRESS_CYC(64)) uut (
		.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .power_button_input(power_button_input),
		.standby_in(standby_in), .vin_above_uv(vin_above_uv),
		.thermal_shutdown(thermal_shutdown), .fault_in(fault_in),
		.irq_out_n(irq_out_n), .host_reset_out_n(host_reset_out_n),
		.buck_enable(buck_enable), .buck_pfm(buck_pfm),
		.buck_sleep_sel(sel), .buck_startup_req(buck_startup_req),
		.buck1_sleep_setpoint(sp1), .buck2_sleep_setpoint(sp2),
		.buck3_sleep_setpoint(sp3), .power_state(power_state));
	always #12.5 clk_sys = ~clk_sys;

	// ==========================================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		chk(reg_rdata, exp);
	endtask
	task automatic wait_st(input logic [2:0] s, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			su = su | buck_startup_req;
			if (power_state === s)
				break;
			@(posedge clk_sys);
		end
		chk(8'(power_state), 8'(s));
		if (i == lim)
			wrap_up();
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		clk_sys = 1'b0;
		{srst, reg_wr, reg_rd, btn, stby, vin, hot} = 7'h40;
		{reg_addr, reg_wdata, fault_in, su} = 23'h0;
		fail_count = 0;
		n_tests = 0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		chk(8'(host_reset_out_n), 8'h00);
		rdc(8'h00, 8'h00);
		rdc(8'h10, 8'h00);
		btn <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk(8'(power_state), 8'h00);
		$display("test coin ended");
		vin <= 1'b1;
		wait_st(3'h4, 20);
		chk(8'(host_reset_out_n), 8'h01);
		rdc(8'h06, 8'h13);
		$display("test power-up ended");
		wr(8'h01, 8'h05);
		wr(8'h02, 8'h2A);
		wr(8'h03, 8'h55);
		wr(8'h04, 8'h7F);
		wr(8'h06, 8'h01);
		rdc(8'h06, 8'h12);
		btn <= 1'b0;
		wait_st(3'h2, 20);
		chk(8'(buck_enable), 8'h05);
		chk(8'(buck_pfm), 8'h05);
		chk(8'(sel), 8'h01);
		chk(8'(sp2), 8'h55);
		chk(8'(sp3), 8'h7F);
		wr(8'h02, 8'h11);
		chk(8'(sp1), 8'h2A);
		rdc(8'h06, 8'h08);
		fault_in <= 4'h1;
		repeat (6) @(posedge clk_sys);
		chk(8'(irq_out_n), 8'h00);
		wr(8'h05, 8'h02);
		repeat (2) @(posedge clk_sys);
		chk(8'(irq_out_n), 8'h01);
		$display("test sleep ended");
		su = 3'h0;
		btn <= 1'b1;
		wait_st(3'h4, 20);
		chk(8'(su), 8'h02);
		chk(8'(sel), 8'h00);
		$display("test wake ended");
		stby <= 1'b1;
		wait_st(3'h3, 20);
		stby <= 1'b0;
		wait_st(3'h4, 20);
		wr(8'h00, 8'h20);
		wait_st(3'h3, 20);
		$display("test standby ended");
		wr(8'h01, 8'h00);
		btn <= 1'b0;
		wait_st(3'h1, 20);
		chk(8'(host_reset_out_n), 8'h00);
		rdc(8'h06, 8'h04);
		$display("test off ended");
		{hot, btn} <= 2'b11;
		repeat (10) @(posedge clk_sys);
		chk(8'(power_state), 8'h01);
		wr(8'h00, 8'h03);
		hot <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk(8'(power_state), 8'h01);
		$display("test thermal ended");
		btn <= 1'b0;
		wait_st(3'h4, 10);
		repeat (12) @(posedge clk_sys);
		wr(8'h06, 8'h01);
		btn <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rdc(8'h06, 8'h13);
		btn <= 1'b0;
		wait_st(3'h1, 90);
		$display("test switch ended");
		wr(8'h00, 8'h07);
		btn <= 1'b1;
		repeat (12) @(posedge clk_sys);
		btn <= 1'b0;
		wait_st(3'h4, 10);
		wait_st(3'h1, 90);
		wait_st(3'h4, 4);
		btn <= 1'b1;
		$display("test restart ended");
		hot <= 1'b1;
		wait_st(3'h1, 20);
		wr(8'h00, 8'h1B);
		{hot, btn} <= 2'b00;
		repeat (16) @(posedge clk_sys);
		chk(8'(power_state), 8'h01);
		wait_st(3'h4, 20);
		$display("test debounce ended");
		vin <= 1'b0;
		wait_st(3'h0, 20);
		chk(8'(host_reset_out_n), 8'h00);
		$display("test brownout ended");
		srst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rdc(8'h00, 8'h00);
		$display("test reset ended");
		wrap_up();
	end
endmodule
